// ### verilog/sdl_service_limiter.sv
// service displacement demand selection and limiting
//
// Contract
// - mode 0..2: displacement, pressure, load-sense
// - reference source 1 local, 2 network
// - only selected mode's reference is used
// - network reference: local writes ignored, net readback
// - displacement target 0..10000, default zero
// - pressure target 0..420 bar, default zero
// - load-sense keeps margin 0..100 bar
// - output is minimum of demand and limits
// - derate source 0 unlimited, 1 local
// - at or below start pressure: 100 percent
// - linear fall to 0 at end pressure
// - flow cap source 0, 1 or 2
// - flow cap scales displacement by shaft speed
// - torque cap source 0, 1 or 2
// - torque cap scales displacement by pressure
// - power cap source 0, 1 or 2
// - power cap scales by pressure and speed
// - network limit: read-only, shows last received
`timescale 1ns/1ps
`include "sdl_consts.svh"
module sdl_service_limiter #(
   parameter int DW      = 16,
   parameter int DISP_CC = 100
)(
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   // register port
   input  wire logic [3:0]         regAddr,
   input  wire logic [15:0]        regWrData,
   input  wire logic               regWrEn,
   input  wire logic               regRdEn,
   output logic      [15:0]        regRdData,
   // network values
   input  wire logic               netValid,
   input  wire logic [2:0]         netIndex,
   input  wire logic [15:0]        netData,
   // measurements and pressure loop
   input  wire logic [15:0]        outletPress,
   input  wire logic [15:0]        lsPress,
   input  wire logic signed [15:0] shaftSpeed,
   input  wire logic [15:0]        loopDemand,
   // service output
   output logic      [15:0]        svcDisp,
   output logic      [15:0]        pressTarget
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (DW != 16) begin : g_bad_dw
      $error("sdl_service_limiter: DW must be 16");
   end
   if (DISP_CC < 1 || DISP_CC > 1023) begin : g_bad_cc
      $error("sdl_service_limiter: DISP_CC out of 1..1023");
   end

   localparam logic [47:0] CC = 48'(DISP_CC);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   sdl_pkg::sdl_mode_t  mode_ff;
   sdl_pkg::sdl_state_t state_ff;
   logic [1:0]          refSrc_ff;
   logic [1:0]          drSrc_ff;
   logic [1:0]          flSrc_ff;
   logic [1:0]          tqSrc_ff;
   logic [1:0]          pwSrc_ff;
   logic [15:0]         disp_ff;
   logic [15:0]         press_ff;
   logic [15:0]         margin_ff;
   logic [15:0]         drStart_ff;
   logic [15:0]         drEnd_ff;
   logic [15:0]         flow_ff;
   logic [15:0]         torque_ff;
   logic [15:0]         power_ff;
   logic [15:0]         netVal_ff [6];
   logic [15:0]         lim_ff [4];
   logic [15:0]         rdData_ff;
   logic [15:0]         svcDisp_ff;
   logic [15:0]         pTgt_ff;
   logic [1:0]          idx_ff;
   logic [47:0]         quo_ff;
   logic [47:0]         rem_ff;
   logic [47:0]         den_ff;
   logic [5:0]          cnt_ff;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] pick(input logic [1:0] src,
                                        input logic [15:0] loc,
                                        input logic [15:0] net);
      return (src == `SDL_SRC_NET) ? net : loc;
   endfunction

   function automatic logic [15:0] clampFull(input logic [47:0] v);
      return (v > 48'(`SDL_FULL)) ? `SDL_FULL : v[15:0];
   endfunction

   function automatic logic [15:0] minOf(input logic [15:0] a,
                                         input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   // local write to an address, with range check
   function automatic logic okWr(input logic [3:0] a,
                                 input logic [15:0] max);
      return regWrEn && (regAddr == a) && (regWrData <= max);
   endfunction

   logic [15:0] dispEff;
   logic [15:0] pressEff;
   logic [15:0] marginEff;
   logic [15:0] flowEff;
   logic [15:0] torqueEff;
   logic [15:0] powerEff;
   logic [15:0] speedAbs;
   logic        refNet;

   assign refNet    = (refSrc_ff == `SDL_SRC_NET);
   assign dispEff   = pick(refSrc_ff, disp_ff, netVal_ff[0]);
   assign pressEff  = pick(refSrc_ff, press_ff, netVal_ff[1]);
   assign marginEff = pick(refSrc_ff, margin_ff, netVal_ff[2]);
   assign flowEff   = pick(flSrc_ff, flow_ff, netVal_ff[3]);
   assign torqueEff = pick(tqSrc_ff, torque_ff, netVal_ff[4]);
   assign powerEff  = pick(pwSrc_ff, power_ff, netVal_ff[5]);
   assign speedAbs  = shaftSpeed[15] ? 16'(-shaftSpeed)
                                     : 16'(shaftSpeed);

   // ----------------------------------------------------------------
   // mode and source selectors
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         mode_ff   <= sdl_pkg::MODE_DISP;
         refSrc_ff <= `SDL_REFSRC_RST;
         drSrc_ff  <= `SDL_SRC_NONE;
         flSrc_ff  <= `SDL_SRC_NONE;
         tqSrc_ff  <= `SDL_SRC_NONE;
         pwSrc_ff  <= `SDL_SRC_NONE;
      end
      else
      begin
         if (okWr(`SDL_A_MODE, `SDL_MODE_MAX))
            mode_ff <= sdl_pkg::sdl_mode_t'(regWrData[1:0]);
         if (okWr(`SDL_A_REFSRC, 16'h0002) && regWrData != 16'h0000)
            refSrc_ff <= regWrData[1:0];
         if (okWr(`SDL_A_DRSRC, 16'h0001))
            drSrc_ff <= regWrData[1:0];
         if (okWr(`SDL_A_FLSRC, 16'h0002))
            flSrc_ff <= regWrData[1:0];
         if (okWr(`SDL_A_TQSRC, 16'h0002))
            tqSrc_ff <= regWrData[1:0];
         if (okWr(`SDL_A_PWSRC, 16'h0002))
            pwSrc_ff <= regWrData[1:0];
      end
   end

   // ----------------------------------------------------------------
   // local reference values, writable only with the local source
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         disp_ff   <= 16'h0000;
         press_ff  <= 16'h0000;
         margin_ff <= 16'h0000;
      end
      else if (!refNet)
      begin
         if (okWr(`SDL_A_DISP, `SDL_FULL))
            disp_ff <= regWrData;
         if (okWr(`SDL_A_PRESS, `SDL_PRESS_MAX))
            press_ff <= regWrData;
         if (okWr(`SDL_A_MARGIN, `SDL_MARGIN_MAX))
            margin_ff <= regWrData;
      end
   end

   // ----------------------------------------------------------------
   // local limit values
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         drStart_ff <= 16'h0000;
         drEnd_ff   <= 16'h0000;
         flow_ff    <= 16'h0000;
         torque_ff  <= 16'h0000;
         power_ff   <= 16'h0000;
      end
      else
      begin
         if (okWr(`SDL_A_DRSTART, `SDL_PRESS_MAX))
            drStart_ff <= regWrData;
         if (okWr(`SDL_A_DREND, `SDL_DREND_MAX))
            drEnd_ff <= regWrData;
         if (okWr(`SDL_A_FLOW, `SDL_FLOW_MAX) && flSrc_ff != `SDL_SRC_NET)
            flow_ff <= regWrData;
         if (okWr(`SDL_A_TORQUE, `SDL_TORQUE_MAX)
             && tqSrc_ff != `SDL_SRC_NET)
            torque_ff <= regWrData;
         if (okWr(`SDL_A_POWER, `SDL_POWER_MAX)
             && pwSrc_ff != `SDL_SRC_NET)
            power_ff <= regWrData;
      end
   end

   // ----------------------------------------------------------------
   // network holding registers
   // ----------------------------------------------------------------
   logic [15:0] netMax;

   always_comb
   begin
      unique case (netIndex)
         `SDL_NET_DISP:   netMax = `SDL_FULL;
         `SDL_NET_PRESS:  netMax = `SDL_PRESS_MAX;
         `SDL_NET_MARGIN: netMax = `SDL_MARGIN_MAX;
         `SDL_NET_FLOW:   netMax = `SDL_FLOW_MAX;
         `SDL_NET_TORQUE: netMax = `SDL_TORQUE_MAX;
         `SDL_NET_POWER:  netMax = `SDL_POWER_MAX;
         default:         netMax = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 6; i++)
            netVal_ff[i] <= 16'h0000;
      end
      else if (netValid && netIndex <= `SDL_NET_POWER
               && netData <= netMax)
         netVal_ff[netIndex] <= netData;
   end

   // ----------------------------------------------------------------
   // register readback, one cycle after the read strobe
   // ----------------------------------------------------------------
   logic [15:0] rdMux;

   always_comb
   begin
      unique case (regAddr)
         `SDL_A_MODE:    rdMux = {14'h0000, mode_ff};
         `SDL_A_REFSRC:  rdMux = {14'h0000, refSrc_ff};
         `SDL_A_DISP:    rdMux = dispEff;
         `SDL_A_PRESS:   rdMux = pressEff;
         `SDL_A_MARGIN:  rdMux = marginEff;
         `SDL_A_DRSRC:   rdMux = {14'h0000, drSrc_ff};
         `SDL_A_DRSTART: rdMux = drStart_ff;
         `SDL_A_DREND:   rdMux = drEnd_ff;
         `SDL_A_FLSRC:   rdMux = {14'h0000, flSrc_ff};
         `SDL_A_FLOW:    rdMux = flowEff;
         `SDL_A_TQSRC:   rdMux = {14'h0000, tqSrc_ff};
         `SDL_A_TORQUE:  rdMux = torqueEff;
         `SDL_A_PWSRC:   rdMux = {14'h0000, pwSrc_ff};
         `SDL_A_POWER:   rdMux = powerEff;
         `SDL_A_STDISP:  rdMux = svcDisp_ff;
         `SDL_A_STPTGT:  rdMux = pTgt_ff;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rdData_ff <= 16'h0000;
      else
         rdData_ff <= regRdEn ? rdMux : 16'h0000;
   end

   // ----------------------------------------------------------------
   // limit set-up: numerator, denominator or a direct value
   // ----------------------------------------------------------------
   logic        bypass;
   logic [15:0] bypVal;
   logic [47:0] num;
   logic [47:0] den;

   always_comb
   begin
      bypass = 1'b1;
      bypVal = `SDL_FULL;
      num    = 48'h0;
      den    = 48'h0;
      unique case (idx_ff)
         2'h0:
         begin
            if (drSrc_ff == `SDL_SRC_NONE)
               bypVal = `SDL_FULL;
            else if (outletPress <= drStart_ff)
               bypVal = `SDL_FULL;
            else if (outletPress >= drEnd_ff)
               bypVal = 16'h0000;
            else
            begin
               bypass = 1'b0;
               num = 48'(drEnd_ff - outletPress) * 48'(`SDL_FULL);
               den = 48'(drEnd_ff - drStart_ff);
            end
         end
         2'h1:
         begin
            den = CC * 48'(speedAbs);
            num = 48'(flowEff) * `SDL_FLOW_K;
            bypass = (flSrc_ff == `SDL_SRC_NONE) || (den == 48'h0);
         end
         2'h2:
         begin
            den = CC * 48'(outletPress);
            num = 48'(torqueEff) * `SDL_TORQUE_K;
            bypass = (tqSrc_ff == `SDL_SRC_NONE) || (den == 48'h0);
         end
         2'h3:
         begin
            den = CC * 48'(outletPress) * 48'(speedAbs);
            num = 48'(powerEff) * `SDL_POWER_K;
            bypass = (pwSrc_ff == `SDL_SRC_NONE) || (den == 48'h0);
         end
      endcase
   end

   // ----------------------------------------------------------------
   // shared serial divider, one limit at a time
   // ----------------------------------------------------------------
   logic [48:0] trial;

   assign trial = {rem_ff, quo_ff[47]};

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_ff <= sdl_pkg::ST_PREP;
         idx_ff   <= 2'h0;
         quo_ff   <= 48'h0;
         rem_ff   <= 48'h0;
         den_ff   <= 48'h0;
         cnt_ff   <= 6'h00;
         for (int i = 0; i < 4; i++)
            lim_ff[i] <= `SDL_FULL;
      end
      else
      begin
         unique case (state_ff)
            sdl_pkg::ST_PREP:
            begin
               rem_ff <= 48'h0;
               den_ff <= den;
               cnt_ff <= `SDL_DIV_LAST;
               quo_ff <= bypass ? 48'(bypVal) : num;
               state_ff <= bypass ? sdl_pkg::ST_SAVE : sdl_pkg::ST_DIV;
            end
            sdl_pkg::ST_DIV:
            begin
               if (trial >= {1'b0, den_ff})
               begin
                  rem_ff <= 48'(trial - {1'b0, den_ff});
                  quo_ff <= {quo_ff[46:0], 1'b1};
               end
               else
               begin
                  rem_ff <= trial[47:0];
                  quo_ff <= {quo_ff[46:0], 1'b0};
               end
               cnt_ff <= cnt_ff - 6'h01;
               if (cnt_ff == 6'h00)
                  state_ff <= sdl_pkg::ST_SAVE;
            end
            sdl_pkg::ST_SAVE:
            begin
               lim_ff[idx_ff] <= clampFull(quo_ff);
               idx_ff <= idx_ff + 2'h1;
               state_ff <= sdl_pkg::ST_PREP;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // demand of the selected mode and minimum selection
   // ----------------------------------------------------------------
   logic [15:0] demand;
   logic [15:0] limMin;

   assign demand = (mode_ff == sdl_pkg::MODE_DISP)
                   ? dispEff
                   : clampFull(48'(loopDemand));
   assign limMin = minOf(minOf(lim_ff[0], lim_ff[1]),
                         minOf(lim_ff[2], lim_ff[3]));

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         svcDisp_ff <= 16'h0000;
         pTgt_ff    <= 16'h0000;
      end
      else
      begin
         svcDisp_ff <= minOf(demand, limMin);
         unique case (mode_ff)
            sdl_pkg::MODE_DISP:  pTgt_ff <= 16'h0000;
            sdl_pkg::MODE_PRESS: pTgt_ff <= pressEff;
            sdl_pkg::MODE_LS:    pTgt_ff <= 16'(lsPress + marginEff);
         endcase
      end
   end

   assign regRdData   = rdData_ff;
   assign svcDisp     = svcDisp_ff;
   assign pressTarget = pTgt_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_prep_div;
      state_ff == sdl_pkg::ST_PREP && !bypass;
   endsequence
   sequence s_divide;
      (state_ff == sdl_pkg::ST_DIV) [*8];
   endsequence

   a_mode_range: assert property (
      regWrEn && regAddr == `SDL_A_MODE && regWrData > `SDL_MODE_MAX
      |=> $stable(mode_ff))
      else $error("mode took an illegal value");

   a_refsrc_zero: assert property (
      regWrEn && regAddr == `SDL_A_REFSRC && regWrData == 16'h0000
      |=> refSrc_ff != `SDL_SRC_NONE)
      else $error("reference source took zero");

   a_ref_locked: assert property (
      refNet && regWrEn && regAddr == `SDL_A_DISP
      |=> $stable(disp_ff))
      else $error("local write changed network reference");

   a_net_hold: assert property (
      netValid && netIndex == `SDL_NET_FLOW && netData <= `SDL_FLOW_MAX
      |=> netVal_ff[3] == $past(netData))
      else $error("network flow value not held");

   a_read_back: assert property (
      regRdEn && regAddr == `SDL_A_FLOW && flSrc_ff == `SDL_SRC_NET
      |=> regRdData == $past(netVal_ff[3]))
      else $error("network limit readback wrong");

   a_out_min: assert property (
      ##1 svcDisp <= $past(limMin) && svcDisp <= $past(demand))
      else $error("output above a limit or demand");

   a_derate_low: assert property (
      state_ff == sdl_pkg::ST_PREP && idx_ff == 2'h0
      && drSrc_ff != `SDL_SRC_NONE && outletPress <= drStart_ff
      |=> ##1 lim_ff[0] == `SDL_FULL)
      else $error("derate below start not full");

   a_derate_high: assert property (
      state_ff == sdl_pkg::ST_PREP && idx_ff == 2'h0
      && drSrc_ff != `SDL_SRC_NONE && outletPress > drStart_ff
      && outletPress >= drEnd_ff
      |=> ##1 lim_ff[0] == 16'h0000)
      else $error("derate above end not zero");

   a_flow_open: assert property (
      state_ff == sdl_pkg::ST_PREP && idx_ff == 2'h1
      && flSrc_ff == `SDL_SRC_NONE
      |=> ##1 lim_ff[1] == `SDL_FULL)
      else $error("unlimited flow cap restricts");

   a_div_len: assert property (
      s_prep_div |=> s_divide ##41 state_ff == sdl_pkg::ST_SAVE)
      else $error("divider length wrong");

   a_disp_mode: assert property (
      mode_ff == sdl_pkg::MODE_DISP && limMin == `SDL_FULL
      |=> svcDisp == $past(dispEff))
      else $error("displacement mode output wrong");

endmodule

// ### include/sdl_consts.svh
// offsets, field limits, reset values and scale factors of the limiter
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SDL_A_MODE     4'h0
`define SDL_A_REFSRC   4'h1
`define SDL_A_DISP     4'h2
`define SDL_A_PRESS    4'h3
`define SDL_A_MARGIN   4'h4
`define SDL_A_DRSRC    4'h5
`define SDL_A_DRSTART  4'h6
`define SDL_A_DREND    4'h7
`define SDL_A_FLSRC    4'h8
`define SDL_A_FLOW     4'h9
`define SDL_A_TQSRC    4'ha
`define SDL_A_TORQUE   4'hb
`define SDL_A_PWSRC    4'hc
`define SDL_A_POWER    4'hd
`define SDL_A_STDISP   4'he
`define SDL_A_STPTGT   4'hf
// ----------------------------------------------------------------
// value ranges and reset values
// ----------------------------------------------------------------
`define SDL_FULL       16'h2710
`define SDL_PRESS_MAX  16'h01a4
`define SDL_MARGIN_MAX 16'h0064
`define SDL_DREND_MAX  16'h01c2
`define SDL_FLOW_MAX   16'h012c
`define SDL_TORQUE_MAX 16'h05dc
`define SDL_POWER_MAX  16'h01f4
`define SDL_MODE_MAX   16'h0002
`define SDL_SRC_NONE   2'h0
`define SDL_SRC_LOCAL  2'h1
`define SDL_SRC_NET    2'h2
`define SDL_REFSRC_RST 2'h1
// ----------------------------------------------------------------
// network value indexes
// ----------------------------------------------------------------
`define SDL_NET_DISP   3'h0
`define SDL_NET_PRESS  3'h1
`define SDL_NET_MARGIN 3'h2
`define SDL_NET_FLOW   3'h3
`define SDL_NET_TORQUE 3'h4
`define SDL_NET_POWER  3'h5
// ----------------------------------------------------------------
// limit scale factors and divider length
// ----------------------------------------------------------------
`define SDL_FLOW_K     48'h000000989680
`define SDL_TORQUE_K   48'h00000009965f
`define SDL_POWER_K    48'h000165a0bc00
`define SDL_DIV_LAST   6'h2f
`endif

// ### include/sdl_pkg.sv
// types shared by the service displacement limiter
package sdl_pkg;
   typedef enum logic [1:0] {MODE_DISP, MODE_PRESS, MODE_LS} sdl_mode_t;
   typedef enum logic [1:0] {ST_PREP, ST_DIV, ST_SAVE} sdl_state_t;
endpackage

// ### bench/sdl_net_node.sv
// network node model that delivers values to the limiter
`timescale 1ns/1ps
module sdl_net_node (
   // clock
   input  wire logic    ref_clk,
   // network values
   output logic         netValid,
   output logic [2:0]   netIndex,
   output logic [15:0]  netData
);
   logic        sending  = 1'b0;
   logic [2:0]  idxHold  = 3'h0;
   logic [15:0] dataHold = 16'h0000;
   logic [15:0] idlePat  = 16'h5a5a;
   // ----
   // line levels
   // ----
   // between messages the data lines change every cycle, the index lines hold the inverse of the last index
   always @(posedge ref_clk)
      idlePat <= {idlePat[14:0], ~idlePat[15]};
   assign netValid = sending;
   assign netIndex = sending ? idxHold : ~idxHold;
   assign netData  = sending ? dataHold : idlePat;
   // one message, one cycle long
   task automatic send(input logic [2:0] idx, input logic [15:0] d);
      @(posedge ref_clk);
      idxHold  <= idx;
      dataHold <= d;
      sending  <= 1'b1;
      @(posedge ref_clk);
      sending  <= 1'b0;
   endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench of the service displacement limiter
`timescale 1ns/1ps
module tb_top;
   logic               ref_clk     = 1'b0;
   logic               sys_rst     = 1'b1;
   logic [3:0]         regAddr     = 4'h0;
   logic [15:0]        regWrData   = 16'h0000;
   logic               regWrEn     = 1'b0;
   logic               regRdEn     = 1'b0;
   logic [15:0]        regRdData;
   logic               netValid;
   logic [2:0]         netIndex;
   logic [15:0]        netData;
   logic [15:0]        outletPress = 16'h0000;
   logic [15:0]        lsPress     = 16'h0064;
   logic signed [15:0] shaftSpeed  = 16'sh07d0;
   logic [15:0]        loopDemand  = 16'h0bb8;
   logic [15:0]        svcDisp;
   logic [15:0]        pressTarget;
   int                 errors       = 0;
   int                 total_checks = 0;
   int                 cycles       = 0;
   // {address, write value, read-back value}
   logic [35:0]        tbl [20] = '{
      36'h0_0002_0002, 36'h0_0003_0002, 36'h1_0000_0001, 36'h1_0003_0001,
      36'h2_2710_2710, 36'h2_2711_2710, 36'h3_01a4_01a4, 36'h3_01a5_01a4,
      36'h4_0064_0064, 36'h4_0065_0064, 36'h5_0001_0001, 36'h5_0002_0001,
      36'h6_01a5_0000, 36'h7_01c3_0000, 36'h8_0002_0002, 36'h8_0003_0002,
      36'ha_0002_0002, 36'ha_0003_0002, 36'hc_0002_0002, 36'hc_0003_0002};
   logic [19:0]        setup [8] = '{20'h0_0000, 20'h5_0000, 20'h8_0000,
      20'ha_0000, 20'hc_0000, 20'h2_1388, 20'h3_00c8, 20'h4_001e};
   // {outlet pressure, expected displacement}
   logic [31:0]        drt [3] = '{32'h0064_2710, 32'h00c8_1388,
      32'h012c_0000};

   sdl_service_limiter #(.DW(16), .DISP_CC(100)) sdl_service_limiter_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .netValid(netValid), .netIndex(netIndex),
      .netData(netData), .outletPress(outletPress), .lsPress(lsPress),
      .shaftSpeed(shaftSpeed), .loopDemand(loopDemand),
      .svcDisp(svcDisp), .pressTarget(pressTarget));
   sdl_net_node sdl_net_node_i (.ref_clk(ref_clk), .netValid(netValid),
      .netIndex(netIndex), .netData(netData));

   // ----
   // clock, timeout and tasks
   // ----
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge ref_clk);
      regWrEn   <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1;
      cmp("regRdData", exp, regRdData);
   endtask
   // a limit settles within one rotation of the limit engine
   task automatic outIs(input logic [15:0] exp);
      repeat (250) @(posedge ref_clk);
      #1;
      cmp("svcDisp", exp, svcDisp);
   endtask

   // ----
   // scenarios
   // ----
   initial
   begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (tbl[i])
         rd(tbl[i][35:32], {15'h0000, tbl[i][35:32] == 4'h1});
      @(posedge ref_clk);
      #1;
      cmp("regRdData", 16'h0000, regRdData);
      foreach (tbl[i])
      begin
         wr(tbl[i][35:32], tbl[i][31:16]);
         rd(tbl[i][35:32], tbl[i][15:0]);
      end
      foreach (setup[i])
         wr(setup[i][19:16], setup[i][15:0]);
      outIs(16'h1388);
      cmp("pressTarget", 16'h0000, pressTarget);
      wr(4'h0, 16'h0001);
      outIs(16'h0bb8);
      cmp("pressTarget", 16'h00c8, pressTarget);
      wr(4'h0, 16'h0002);
      outIs(16'h0bb8);
      cmp("pressTarget", 16'h0082, pressTarget);
      wr(4'h0, 16'h0000);
      sdl_net_node_i.send(3'h0, 16'h1b58);
      rd(4'h2, 16'h1388);
      wr(4'h1, 16'h0002);
      rd(4'h2, 16'h1b58);
      wr(4'h2, 16'h0064);
      rd(4'h2, 16'h1b58);
      sdl_net_node_i.send(3'h0, 16'h2711);
      rd(4'h2, 16'h1b58);
      sdl_net_node_i.send(3'h1, 16'h0096);
      wr(4'h0, 16'h0001);
      rd(4'h3, 16'h0096);
      cmp("pressTarget", 16'h0096, pressTarget);
      wr(4'h0, 16'h0000);
      outIs(16'h1b58);
      sdl_net_node_i.send(3'h3, 16'h0064);
      wr(4'h8, 16'h0002);
      wr(4'h9, 16'h00c8);
      rd(4'h9, 16'h0064);
      outIs(16'h1388);
      @(posedge ref_clk);
      shaftSpeed <= -16'sh07d0;
      outIs(16'h1388);
      wr(4'h8, 16'h0000);
      wr(4'h1, 16'h0001);
      wr(4'h2, 16'h2710);
      wr(4'h5, 16'h0001);
      wr(4'h6, 16'h0064);
      wr(4'h7, 16'h012c);
      foreach (drt[i])
      begin
         @(posedge ref_clk);
         outletPress <= drt[i][31:16];
         outIs(drt[i][15:0]);
      end
      wr(4'h5, 16'h0000);
      outIs(16'h2710);
      @(posedge ref_clk);
      outletPress <= 16'h00c8;
      wr(4'ha, 16'h0001);
      wr(4'hb, 16'h0064);
      outIs(16'h0c45);
      wr(4'ha, 16'h0000);
      @(posedge ref_clk);
      shaftSpeed <= 16'sh05dc;
      wr(4'hc, 16'h0001);
      wr(4'hd, 16'h0014);
      outIs(16'h0fa0);
      wr(4'ha, 16'h0001);
      outIs(16'h0c45);
      sdl_net_node_i.send(3'h4, 16'h0032);
      wr(4'ha, 16'h0002);
      wr(4'hb, 16'h0064);
      rd(4'hb, 16'h0032);
      outIs(16'h0622);
      give_verdict();
   end
endmodule
